// [scc_host.sv]
/*
  Host end: serial register master. Takes a command (read flag, address,
  byte count), runs one streaming frame, asks for each write byte and returns
  each read byte. Mirrors the hold and direction bits from its own writes so
  each byte is masked for the register that really takes it.
*/
`timescale 1ns/10ps

module scc_host #(
  parameter int unsigned HALF = scc_pkg::SCLK_HALF_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  scc_spi_if.host          spi,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_read,
  input  wire logic [14:0] cmd_addr,
  input  wire logic [3:0]  cmd_len,     // bytes minus one
  input  wire logic [7:0]  cmd_wdata,
  output logic             cmd_ready,
  output logic             wdata_taken,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data
);

  typedef enum logic [1:0] {SCC_IDLE, SCC_RUN, SCC_TAIL} scc_state_t;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  scc_state_t  state_q;
  logic [7:0]  div_q;
  logic        sclk_q, csn_q, sdi_q, ready_q, taken_q, rsp_q, rd_q, done_q;
  logic [4:0]  cnt_q;
  logic [15:0] sh_q;
  logic [7:0]  rx_q;
  logic [3:0]  left_q;
  logic [14:0] addr_q;
  logic        hold_q;   // copy of the device's address hold
  logic        asc_q;    // copy of the device's direction
  logic [7:0]  last_q;   // byte now being sent

  // reserved bits forced to defaults; receiver enable forced on when processor is set
  function automatic logic [7:0] scc_clean(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] r;
    r = d;
    case (a)
      scc_pkg::CLOCK_CTRL0_ADDR: begin
        r = (d & scc_pkg::CLOCK_CTRL0_USER)
            | (scc_pkg::CLOCK_CTRL0_RST & ~scc_pkg::CLOCK_CTRL0_USER);
        if (r[scc_pkg::PROC_EN_BIT]) begin
          r[scc_pkg::RECV_EN_BIT] = 1'b1;
        end
      end
      scc_pkg::CLOCK_CTRL1_ADDR: r = d & scc_pkg::CLOCK_CTRL1_USER;
      scc_pkg::CLOCK_CTRL2_ADDR: begin
        r = (d & scc_pkg::CLOCK_CTRL2_USER)
            | (scc_pkg::CLOCK_CTRL2_RST & ~scc_pkg::CLOCK_CTRL2_USER);
      end
      scc_pkg::USER_SERIAL_ADDR: r = d & scc_pkg::USER_SERIAL_USER;
      default:                   r = d;
    endcase
    return r;
  endfunction

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  wire        tick      = (div_q == 8'(HALF - 1));
  wire        at_rise   = tick & ~sclk_q;
  wire        at_fall   = tick & sclk_q;
  wire        byte_end  = (cnt_q == scc_pkg::BYTE_LAST);
  wire        load_pt   = (cnt_q == scc_pkg::HDR_LAST) | byte_end;
  // step as the device will: held, else up or down
  wire [14:0] next_addr = (!byte_end || hold_q) ? addr_q :
                          asc_q ? addr_q + 15'h0001 : addr_q - 15'h0001;
  // delay choice and fine step pass as given; the user picks them from
  // capture position read back, at fast clocks with fine step set
  wire [7:0]  next_byte = scc_clean(next_addr, cmd_wdata);

  // ------------------------------------------------------------------
  // frame sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= SCC_IDLE;
      div_q   <= 8'h00;
      sclk_q  <= 1'b0;
      csn_q   <= 1'b1;
      sdi_q   <= 1'b0;
      ready_q <= 1'b0;
      taken_q <= 1'b0;
      rsp_q   <= 1'b0;
      rd_q    <= 1'b0;
      done_q  <= 1'b0;
      cnt_q   <= 5'h00;
      sh_q    <= 16'h0000;
      rx_q    <= 8'h00;
      left_q  <= 4'h0;
      addr_q  <= 15'h0000;
      hold_q  <= scc_pkg::USER_SERIAL_RST[scc_pkg::ADDR_HOLD_BIT];
      asc_q   <= scc_pkg::SERIAL_CONFIG_RST[scc_pkg::ASCEND_BIT];
      last_q  <= 8'h00;
    end else begin
      taken_q <= 1'b0;
      rsp_q   <= 1'b0;
      div_q   <= (state_q == SCC_IDLE || tick) ? 8'h00 : div_q + 8'h01;
      case (state_q)
        SCC_IDLE: begin
          ready_q <= ~(ready_q & cmd_valid);
          if (ready_q && cmd_valid) begin
            state_q <= SCC_RUN;
            csn_q   <= 1'b0;
            sh_q    <= {cmd_read, cmd_addr};
            sdi_q   <= cmd_read;
            rd_q    <= cmd_read;
            addr_q  <= cmd_addr;
            left_q  <= cmd_len;
            cnt_q   <= 5'h00;
            done_q  <= 1'b0;
          end
        end
        SCC_RUN: begin
          if (at_rise) begin
            sclk_q <= 1'b1;
            rx_q   <= {rx_q[6:0], spi.sdo};
            if (byte_end) begin
              rsp_q  <= rd_q;
              done_q <= (left_q == 4'h0);
            end
          end else if (at_fall) begin
            sclk_q <= 1'b0;
            cnt_q  <= byte_end ? scc_pkg::BYTE_FIRST : cnt_q + 5'h01;
            if (byte_end && !rd_q && addr_q == scc_pkg::USER_SERIAL_ADDR) begin
              hold_q <= last_q[scc_pkg::ADDR_HOLD_BIT];
            end
            if (byte_end && !rd_q && addr_q == scc_pkg::SERIAL_CONFIG_ADDR) begin
              asc_q <= last_q[scc_pkg::ASCEND_BIT];
            end
            if (done_q) begin
              state_q <= SCC_TAIL;
            end else if (load_pt) begin
              sh_q    <= {next_byte, 8'h00};
              last_q  <= next_byte;
              sdi_q   <= next_byte[7];
              taken_q <= ~rd_q;
              addr_q  <= next_addr;
              if (byte_end) begin
                left_q <= left_q - 4'h1;
              end
            end else begin
              sh_q  <= {sh_q[14:0], 1'b0};
              sdi_q <= sh_q[14];
            end
          end
        end
        SCC_TAIL: begin
          if (tick) begin
            csn_q   <= 1'b1;
            state_q <= SCC_IDLE;
          end
        end
        default: state_q <= SCC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign spi.sclk    = sclk_q;
  assign spi.csn     = csn_q;
  assign spi.sdi     = sdi_q;
  assign cmd_ready   = ready_q;
  assign wdata_taken = taken_q;
  assign rsp_valid   = rsp_q;
  assign rsp_data    = rx_q;

endmodule // scc_host

// [scc_pkg.sv]
/*
  Constants shared by both ends of the serial register port of the sysref and
  clock control register group: offsets, field positions, reset values and
  frame timing. Assumes nothing of its surroundings.
*/
package scc_pkg;

  // ------------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W      = 15;
  localparam int unsigned HDR_BITS    = 16;  // read flag plus address
  localparam logic [4:0]  HDR_LAST    = 5'h0F;
  localparam logic [4:0]  BYTE_LAST   = 5'h17;
  localparam logic [4:0]  BYTE_FIRST  = 5'h10;

  // sclk half period in clk cycles, 40 ns at 100 MHz
  localparam int unsigned SCLK_HALF_NS     = 40;
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [14:0] SERIAL_CONFIG_ADDR = 15'h0000;
  localparam logic [14:0] USER_SERIAL_ADDR   = 15'h0010;
  localparam logic [14:0] CLOCK_CTRL0_ADDR   = 15'h0029;
  localparam logic [14:0] CLOCK_CTRL1_ADDR   = 15'h002A;
  localparam logic [14:0] CLOCK_CTRL2_ADDR   = 15'h002B;
  localparam logic [14:0] CAPTURE_POS0_ADDR  = 15'h002C;  // bits 7:0
  localparam logic [14:0] CAPTURE_POS1_ADDR  = 15'h002D;  // bits 15:8
  localparam logic [14:0] CAPTURE_POS2_ADDR  = 15'h002E;  // bits 23:16

  // ------------------------------------------------------------------
  // reset values and field positions
  // ------------------------------------------------------------------
  localparam logic [7:0] SERIAL_CONFIG_RST = 8'h30;
  localparam logic [7:0] USER_SERIAL_RST   = 8'h00;
  localparam logic [7:0] CLOCK_CTRL0_RST   = 8'h80;
  localparam logic [7:0] CLOCK_CTRL1_RST   = 8'h00;
  localparam logic [7:0] CLOCK_CTRL2_RST   = 8'h10;

  localparam int unsigned ASCEND_BIT      = 5;
  localparam int unsigned SDO_ACTIVE_BIT  = 4;
  localparam int unsigned ADDR_HOLD_BIT   = 0;
  localparam int unsigned PROC_EN_BIT     = 6;
  localparam int unsigned RECV_EN_BIT     = 5;
  localparam int unsigned FINE_STEP_BIT   = 4;
  localparam int unsigned DELAY_MSB       = 3;
  localparam int unsigned DEVCLK_PECL_BIT = 2;
  localparam int unsigned SYSREF_PECL_BIT = 1;
  localparam int unsigned POLARITY_BIT    = 0;
  localparam int unsigned QUIET_FILT_BIT  = 2;
  localparam int unsigned CLOCK_FILT_BIT  = 0;

  // writable bits of each register; the rest are reserved
  localparam logic [7:0] CLOCK_CTRL0_USER = 8'h7F;
  localparam logic [7:0] CLOCK_CTRL1_USER = 8'h07;
  localparam logic [7:0] CLOCK_CTRL2_USER = 8'h05;
  localparam logic [7:0] USER_SERIAL_USER = 8'h01;

endpackage : scc_pkg

// [scc_spi_if.sv]
/*
  Four-wire serial register port between the host controller and the device.
  Assumes both ends run on the same clk; sdo is a plain output of the device.
*/
`timescale 1ns/10ps

interface scc_spi_if;
  logic sclk;
  logic csn;
  logic sdi;
  logic sdo;

  modport dev (
    input  sclk,
    input  csn,
    input  sdi,
    output sdo
  );

  modport host (
    output sclk,
    output csn,
    output sdi,
    input  sdo
  );
endinterface : scc_spi_if

// [scc_dev.sv]
/*
  Device end: serial register slave holding the sysref and clock control
  registers, with address streaming, read-back of the capture position and
  gating of sysref events. Assumes sclk, csn and sdi are synchronous to clk
  and that sclk half periods span at least three clk cycles.
*/
`timescale 1ns/10ps

// Notes on behaviour
// - address hold keeps streaming address fixed
// - hold clear steps address by direction
// - direction zero decrements, one increments, increments
// - processor enable bit six gates events
// - receiver enable bit five, resets off
// - host enables receiver no later than processor
// - fine step bit shrinks windowing delays
// - host sets fine step at fast clocks
// - four bit delay choice, resets zero
// - host picks delay from capture position
// - read-only 24-bit capture position status
// - polarity flip inverts sysref for alignment
// - device clock pecl mode bit two
// - sysref input pecl mode bit one
// - quiet analog supply filter bit two
// - clock supply filter bit zero
// - host writes defaults into reserved bits
// - first clock control resets to 0x80
// - second resets zero, third resets 0x10
module scc_dev (
  input  wire logic        clk,
  input  wire logic        rstn,
  scc_spi_if.dev           spi,
  input  wire logic [23:0] sysref_capture_position,
  input  wire logic        sysref_in,
  output logic             sysref_event,
  output logic             sysref_processor_enable,
  output logic             sysref_receiver_enable,
  output logic             sysref_fine_delay_step,
  output logic [3:0]       sysref_delay_choice,
  output logic             sysref_polarity_flip,
  output logic             device_clock_pecl_mode,
  output logic             sysref_input_pecl_mode,
  output logic             quiet_analog_supply_filter,
  output logic             clock_supply_filter
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  // reserved bits are kept as written, so a host that
  // breaks the default rule reads back what it wrote
  logic [7:0]  cfg_q;
  logic [7:0]  usr_q;
  logic [7:0]  ctl0_q;
  logic [7:0]  ctl1_q;
  logic [7:0]  ctl2_q;
  logic        sclk_prev_q;
  logic [4:0]  cnt_q;
  logic [14:0] hdr_q;      // read flag and upper address bits as they arrive
  logic        rd_q;
  logic [14:0] addr_q;
  logic [7:0]  rx_q;
  logic [7:0]  tx_q;
  logic        sdo_q;
  logic        event_q;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  // edges against the previous sample; sclk moving
  // while csn is high is never counted
  wire         sclk_rise  = spi.sclk & ~sclk_prev_q & ~spi.csn;
  wire         sclk_fall  = ~spi.sclk & sclk_prev_q & ~spi.csn;
  wire         hdr_done   = sclk_rise & (cnt_q == scc_pkg::HDR_LAST);
  wire         byte_done  = sclk_rise & (cnt_q == scc_pkg::BYTE_LAST);
  wire [14:0]  hdr_addr   = {hdr_q[13:0], spi.sdi};
  wire         addr_hold  = usr_q[scc_pkg::ADDR_HOLD_BIT];
  wire         ascend     = cfg_q[scc_pkg::ASCEND_BIT];
  // next streaming address: hold, else step by the direction bit
  wire [14:0]  step_addr  = addr_hold ? addr_q :
                            ascend ? addr_q + 15'h0001 :
                            addr_q - 15'h0001;
  // read data must be fetched before the byte's first fall
  wire [14:0]  look_addr  = hdr_done ? hdr_addr : step_addr;
  // eighth data bit taken straight from sdi
  wire [7:0]   wr_byte    = {rx_q[6:0], spi.sdi};
  wire         wr_en      = byte_done & ~rd_q;
  // sdo-only port: the active flag always reads one
  wire [7:0]   cfg_rd     = cfg_q | (8'h01 << scc_pkg::SDO_ACTIVE_BIT);
  logic [7:0]  rd_byte;

  // read mux, unmapped addresses read zero
  // capture position is sampled at byte load, not latched
  always_comb begin
    case (look_addr)
      scc_pkg::SERIAL_CONFIG_ADDR: rd_byte = cfg_rd;
      scc_pkg::USER_SERIAL_ADDR:   rd_byte = usr_q;
      scc_pkg::CLOCK_CTRL0_ADDR:   rd_byte = ctl0_q;
      scc_pkg::CLOCK_CTRL1_ADDR:   rd_byte = ctl1_q;
      scc_pkg::CLOCK_CTRL2_ADDR:   rd_byte = ctl2_q;
      scc_pkg::CAPTURE_POS0_ADDR:  rd_byte = sysref_capture_position[7:0];
      scc_pkg::CAPTURE_POS1_ADDR:  rd_byte = sysref_capture_position[15:8];
      scc_pkg::CAPTURE_POS2_ADDR:  rd_byte = sysref_capture_position[23:16];
      default:                     rd_byte = 8'h00;
    endcase
  end

  // ------------------------------------------------------------------
  // serial framing
  // ------------------------------------------------------------------
  // bit counter wraps from the last data bit back to the first, so a frame
  // may stream any number of bytes until csn rises
  // a partial last byte is dropped as csn clears the count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_prev_q <= 1'b0;
      cnt_q       <= 5'h00;
      hdr_q       <= 15'h0000;
      rd_q        <= 1'b0;
      addr_q      <= 15'h0000;
      rx_q        <= 8'h00;
      tx_q        <= 8'h00;
      sdo_q       <= 1'b0;
    end else begin
      sclk_prev_q <= spi.sclk;
      if (spi.csn) begin
        cnt_q <= 5'h00;
        sdo_q <= 1'b0;
      end else begin
        if (sclk_rise) begin
          cnt_q <= (cnt_q == scc_pkg::BYTE_LAST) ? scc_pkg::BYTE_FIRST : cnt_q + 5'h01;
          hdr_q <= hdr_addr;
          rx_q  <= wr_byte;
        end
        if (hdr_done) begin
          rd_q   <= hdr_q[14];
          addr_q <= hdr_addr;
        end
        // step uses the hold and direction bits before this write
        if (byte_done) begin
          addr_q <= step_addr;
        end
        // read data is loaded as the address is settled, shifted on falls
        if (hdr_done || byte_done) begin
          tx_q <= rd_byte;
        end else if (sclk_fall && cnt_q >= scc_pkg::BYTE_FIRST) begin
          sdo_q <= tx_q[7];
          tx_q  <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // registers; a write takes effect on the edge that ends its byte
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q  <= scc_pkg::SERIAL_CONFIG_RST;
      usr_q  <= scc_pkg::USER_SERIAL_RST;
      ctl0_q <= scc_pkg::CLOCK_CTRL0_RST;
      ctl1_q <= scc_pkg::CLOCK_CTRL1_RST;
      ctl2_q <= scc_pkg::CLOCK_CTRL2_RST;
    end else if (wr_en) begin
      // unmapped and read-only addresses fall to default
      case (addr_q)
        scc_pkg::SERIAL_CONFIG_ADDR: cfg_q  <= wr_byte & 8'h6F;  // soft reset not kept
        scc_pkg::USER_SERIAL_ADDR:   usr_q  <= wr_byte;
        scc_pkg::CLOCK_CTRL0_ADDR:   ctl0_q <= wr_byte;
        scc_pkg::CLOCK_CTRL1_ADDR:   ctl1_q <= wr_byte;
        scc_pkg::CLOCK_CTRL2_ADDR:   ctl2_q <= wr_byte;
        default:                     ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // sysref path: ignored unless receiver and processor are on
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_q <= 1'b0;
    end else begin
      // one clk from pin to event
      event_q <= (sysref_in ^ ctl1_q[scc_pkg::POLARITY_BIT])
                 & ctl0_q[scc_pkg::PROC_EN_BIT]
                 & ctl0_q[scc_pkg::RECV_EN_BIT];
    end
  end

  // ------------------------------------------------------------------
  // outputs, straight from the stored bits
  // ------------------------------------------------------------------
  // no decode between register and pin
  assign spi.sdo                    = sdo_q;
  assign sysref_event               = event_q;
  assign sysref_processor_enable    = ctl0_q[scc_pkg::PROC_EN_BIT];
  assign sysref_receiver_enable     = ctl0_q[scc_pkg::RECV_EN_BIT];
  assign sysref_fine_delay_step     = ctl0_q[scc_pkg::FINE_STEP_BIT];
  assign sysref_delay_choice        = ctl0_q[scc_pkg::DELAY_MSB:0];
  assign sysref_polarity_flip       = ctl1_q[scc_pkg::POLARITY_BIT];
  assign device_clock_pecl_mode     = ctl1_q[scc_pkg::DEVCLK_PECL_BIT];
  assign sysref_input_pecl_mode     = ctl1_q[scc_pkg::SYSREF_PECL_BIT];
  assign quiet_analog_supply_filter = ctl2_q[scc_pkg::QUIET_FILT_BIT];
  assign clock_supply_filter        = ctl2_q[scc_pkg::CLOCK_FILT_BIT];

endmodule // scc_dev

// [scc_assertions.sv]
/*
  Concurrent checks on the serial port wires and the sysref control outputs.
  Assumes one clk domain and a host half period of four clk cycles.
*/
`timescale 1ns/10ps

module scc_assertions (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       sclk,
  input wire logic       csn,
  input wire logic       sdo,
  input wire logic       sysref_in,
  input wire logic       sysref_event,
  input wire logic       sysref_processor_enable,
  input wire logic       sysref_receiver_enable,
  input wire logic       sysref_fine_delay_step,
  input wire logic [3:0] sysref_delay_choice,
  input wire logic       sysref_polarity_flip,
  input wire logic       device_clock_pecl_mode,
  input wire logic       sysref_input_pecl_mode,
  input wire logic       quiet_analog_supply_filter,
  input wire logic       clock_supply_filter
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // all stored controls in one vector so idle stability is one check
  wire [11:0] ctl_w = {sysref_processor_enable, sysref_receiver_enable,
                       sysref_fine_delay_step, sysref_delay_choice, sysref_polarity_flip,
                       device_clock_pecl_mode, sysref_input_pecl_mode,
                       quiet_analog_supply_filter, clock_supply_filter};
  wire        both_en = sysref_processor_enable & sysref_receiver_enable;

  // sclk waits a half period low before the first rise of a frame
  sequence lead_low_s;
    !sclk [*3];
  endsequence
  sequence first_rise_s;
    ##[1:8] sclk;
  endsequence

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  reset_values_a: assert property ($rose(rstn) |-> ctl_w == 12'h000)
    else $error("controls not at reset values");
  proc_off_quiet_a: assert property (!sysref_processor_enable |=> !sysref_event)
    else $error("event while processor disabled");
  recv_off_quiet_a: assert property (!sysref_receiver_enable |=> !sysref_event)
    else $error("event while receiver disabled");
  event_follows_a: assert property (both_en && (sysref_in != sysref_polarity_flip)
    |=> sysref_event)
    else $error("event missing");
  polarity_kill_a: assert property (both_en && (sysref_in == sysref_polarity_flip)
    |=> !sysref_event)
    else $error("event not inverted");
  recv_before_proc_a: assert property ($rose(sysref_processor_enable)
    |-> sysref_receiver_enable)
    else $error("processor on without receiver");
  ctl_idle_stable_a: assert property (csn && $past(csn) |-> $stable(ctl_w))
    else $error("control changed outside a frame");
  frame_lead_a: assert property ($fell(csn) |-> lead_low_s ##1 first_rise_s)
    else $error("bad frame lead");
  idle_lines_a: assert property (csn && $past(csn, 2) |-> !sdo && !sclk)
    else $error("serial lines active while idle");
endmodule // scc_assertions

// [test_sysref_clock_control_regs.sv]
/*
  Testbench: host and device ends joined by the serial interface, driven
  through the host command port. Assumes a 100 MHz clk and no other clock.
*/
`timescale 1ns/10ps

module test_sysref_clock_control_regs;
  logic        clk;
  logic        rstn;
  logic        cmd_valid;
  logic        cmd_read;
  logic [14:0] cmd_addr;
  logic [3:0]  cmd_len;
  logic [7:0]  cmd_wdata;
  logic        cmd_ready;
  logic        wdata_taken;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  logic [23:0] sysref_capture_position;
  logic        sysref_in;
  logic        sysref_event;
  logic        sysref_processor_enable;
  logic        sysref_receiver_enable;
  logic        sysref_fine_delay_step;
  logic [3:0]  sysref_delay_choice;
  logic        sysref_polarity_flip;
  logic        device_clock_pecl_mode;
  logic        sysref_input_pecl_mode;
  logic        quiet_analog_supply_filter;
  logic        clock_supply_filter;
  logic [7:0]  wb [8];
  logic [7:0]  rb [8];
  int          failures;
  int          tests_run;

  // outputs regrouped in register layout, reserved bits shown as zero
  wire [7:0] ctl0_v = {1'b0, sysref_processor_enable, sysref_receiver_enable,
                       sysref_fine_delay_step, sysref_delay_choice};
  wire [7:0] ctl1_v = {5'h00, device_clock_pecl_mode, sysref_input_pecl_mode,
                       sysref_polarity_flip};
  wire [7:0] ctl2_v = {5'h00, quiet_analog_supply_filter, 1'b0, clock_supply_filter};

  scc_spi_if spi_if ();
  scc_dev scc_dev_i (.clk, .rstn, .spi(spi_if), .sysref_capture_position, .sysref_in,
    .sysref_event, .sysref_processor_enable, .sysref_receiver_enable,
    .sysref_fine_delay_step, .sysref_delay_choice, .sysref_polarity_flip,
    .device_clock_pecl_mode, .sysref_input_pecl_mode, .quiet_analog_supply_filter,
    .clock_supply_filter);
  scc_host #(.HALF(4)) scc_host_i (.clk, .rstn, .spi(spi_if), .cmd_valid, .cmd_read,
    .cmd_addr, .cmd_len, .cmd_wdata, .cmd_ready, .wdata_taken, .rsp_valid, .rsp_data);
  scc_assertions scc_assertions_i (.clk, .rstn, .sclk(spi_if.sclk), .csn(spi_if.csn),
    .sdo(spi_if.sdo), .sysref_in, .sysref_event, .sysref_processor_enable,
    .sysref_receiver_enable, .sysref_fine_delay_step, .sysref_delay_choice,
    .sysref_polarity_flip, .device_clock_pecl_mode, .sysref_input_pecl_mode,
    .quiet_analog_supply_filter, .clock_supply_filter);

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one frame; bounded waits so a stuck host ends the run
  task automatic xfer(input logic rd, input logic [14:0] a, input int n);
    int k;
    int j;
    int t;
    k = 0;
    j = 0;
    t = 0;
    while (cmd_ready !== 1'b1 && t < 2000) begin
      tick(1);
      t++;
    end
    cmd_read = rd;
    cmd_addr = a;
    cmd_len = 4'(n - 1);
    cmd_wdata = wb[0];
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    while (cmd_ready !== 1'b1 && t < 2000) begin
      if (wdata_taken === 1'b1 && k < 7) begin
        k++;
        cmd_wdata = wb[k];
      end
      if (rsp_valid === 1'b1 && j < 8) begin
        rb[j] = rsp_data;
        j++;
      end
      tick(1);
      t++;
    end
    if (t >= 2000) begin
      failures++;
      $display("FAIL frame wait expected ready seen timeout");
      complete_run();
    end
  endtask

  task automatic wr1(input logic [14:0] a, input logic [7:0] v);
    wb[0] = v;
    xfer(1'b0, a, 1);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    chk("ctl0 outputs", ctl0_v, 8'h00);
    chk("ctl1 outputs", ctl1_v, 8'h00);
    chk("ctl2 outputs", ctl2_v, 8'h00);
    xfer(1'b1, 15'h0029, 3);
    chk("read ctl0", rb[0], 8'h80);
    chk("read ctl1", rb[1], 8'h00);
    chk("read ctl2", rb[2], 8'h10);
    $display("test reset done");
  endtask

  task automatic t_write();
    wb[0] = 8'h5B;  // processor on, receiver left off on purpose
    wb[1] = 8'h07;
    wb[2] = 8'h05;
    xfer(1'b0, 15'h0029, 3);
    chk("ctl0 outputs", ctl0_v, 8'h7B);
    chk("ctl1 outputs", ctl1_v, 8'h07);
    chk("ctl2 outputs", ctl2_v, 8'h05);
    xfer(1'b1, 15'h0029, 3);
    chk("read ctl0", rb[0], 8'hFB);
    chk("read ctl1", rb[1], 8'h07);
    chk("read ctl2", rb[2], 8'h15);
    $display("test write done");
  endtask

  task automatic t_event();
    sysref_in = 1'b0;
    tick(2);
    chk("event inverted low", sysref_event, 8'h01);
    sysref_in = 1'b1;
    tick(2);
    chk("event inverted high", sysref_event, 8'h00);
    wr1(15'h002A, 8'h00);
    tick(2);
    chk("event plain", sysref_event, 8'h01);
    wr1(15'h0029, 8'h20);
    tick(2);
    chk("event gated", sysref_event, 8'h00);
    wr1(15'h0029, 8'h40);
    tick(2);
    chk("receiver forced", sysref_receiver_enable, 8'h01);
    chk("event enabled", sysref_event, 8'h01);
    $display("test event done");
  endtask

  task automatic t_capture();
    xfer(1'b1, 15'h002C, 4);
    chk("position low", rb[0], 8'h3C);
    chk("position mid", rb[1], 8'hC3);
    chk("position high", rb[2], 8'hA5);
    chk("unmapped", rb[3], 8'h00);
    $display("test capture done");
  endtask

  task automatic t_hold();
    wr1(15'h0010, 8'h01);
    wb[0] = 8'h11;
    wb[1] = 8'h02;
    xfer(1'b0, 15'h0029, 2);
    chk("held ctl0", ctl0_v, 8'h02);
    chk("ctl1 untouched", ctl1_v, 8'h00);
    xfer(1'b1, 15'h0029, 2);
    chk("held read 0", rb[0], 8'h82);
    chk("held read 1", rb[1], 8'h82);
    wr1(15'h0010, 8'h00);
    $display("test hold done");
  endtask

  task automatic t_direction();
    wr1(15'h0000, 8'h10);
    xfer(1'b1, 15'h002B, 2);
    chk("down first", rb[0], 8'h15);
    chk("down second", rb[1], 8'h00);
    wr1(15'h0000, 8'h30);
    xfer(1'b1, 15'h002A, 2);
    chk("up first", rb[0], 8'h00);
    chk("up second", rb[1], 8'h15);
    $display("test direction done");
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    failures = 0;
    tests_run = 0;
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 15'h0000;
    cmd_len = 4'h0;
    cmd_wdata = 8'h00;
    sysref_in = 1'b0;
    sysref_capture_position = 24'hA5C33C;
    repeat (3) @(posedge clk);
    #1;
    rstn = 1'b1;
    tick(1);
    t_reset();
    t_write();
    t_event();
    t_capture();
    t_hold();
    t_direction();
    complete_run();
  end
endmodule // test_sysref_clock_control_regs
